// ===== hw/pwm_unit_pkg.sv
// Purpose: Shared constants, types and register map of the LED and auxiliary PWM unit
// Assumes: 32-bit APB, word-aligned registers, 8-bit byte address
// Notes:   Counter 0 serves the LED channels, counters 1 and 2 the auxiliary channels
package pwm_unit_pkg;

	// Sizes
	localparam int NUM_LED = 3;
	localparam int NUM_AUX = 4;
	localparam int NUM_CH  = 7;
	localparam int NUM_CNT = 3;
	localparam int CNT_W   = 16;
	localparam int ADDR_W  = 8;

	typedef logic [CNT_W-1:0]  count_t;
	typedef logic [ADDR_W-1:0] addr_t;

	// One channel's timestamps, fall in the upper half-word
	typedef struct packed {
		count_t fall;
		count_t rise;
	} edge_s;

	// One counter's pre-scaler and period
	typedef struct packed {
		count_t div;
		count_t per;
	} timing_s;

	// Register byte offsets
	localparam addr_t OFS_CTRL     = 8'h00;
	localparam addr_t OFS_INT_STAT = 8'h04;
	localparam addr_t OFS_INT_MASK = 8'h08;
	localparam addr_t OFS_AUX_SEL  = 8'h0C;
	localparam addr_t OFS_TIM_BASE = 8'h10;
	localparam addr_t OFS_TIM_LAST = 8'h24;
	localparam addr_t OFS_CH_BASE  = 8'h40;
	localparam addr_t OFS_CH_LAST  = 8'h58;
	localparam addr_t OFS_OUT_STAT = 8'h60;
	localparam addr_t OFS_CNT_BASE = 8'h70;
	localparam addr_t OFS_CNT_LAST = 8'h78;

	// Address layout of the timing and channel blocks
	localparam int TIM_STRIDE_SH = 3;
	localparam int WORD_SH       = 2;
	localparam int PER_WORD_BIT  = 2;

	// Reset values: channels start dark, counters at full period, divide by one
	localparam count_t RST_DIV  = 16'h0001;
	localparam count_t RST_PER  = 16'hFFFF;
	localparam count_t RST_RISE = 16'hFFFF;
	localparam count_t RST_FALL = 16'h0000;
	localparam count_t CNT_ZERO = 16'h0000;
	localparam count_t CNT_ONE  = 16'h0001;

	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

// ===== hw/led_and_aux_pwm_unit.sv
// Purpose: Three LED PWM channels on one counter plus four auxiliary channels on two shared counters
// Assumes: APB slave, single clock, synchronous active-low reset
// Notes:   Timing and channel settings are staged and take effect at the end of the running period after an update request; mask and aux select act at once
`timescale 1ns/1ns
module led_and_aux_pwm_unit
	import pwm_unit_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_resetn,
	input  wire logic               i_psel,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [ADDR_W-1:0]  i_paddr,
	input  wire logic [31:0]        i_pwdata,
	output logic      [31:0]        o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr,
	output logic                    o_irq,
	output logic      [NUM_LED-1:0] o_led_current_enable,
	output logic      [NUM_AUX-1:0] o_gpio_pwm
);

	// Counter that drives a channel: LED channels use counter 0, auxiliary ones counter 1 or 2
	function automatic int cnt_of(input int ch, input logic [NUM_AUX-1:0] sel);
		int k;
		k = 0;
		if (ch >= NUM_LED) begin
			k = sel[ch-NUM_LED] ? 2 : 1;
		end
		return k;
	endfunction

	// Output level of one channel for a given count
	function automatic logic level_of(input count_t cnt, input edge_s e, input count_t per);
		count_t f;
		logic   lvl;
		f   = e.fall;
		lvl = 1'b0;
		if (e.rise == CNT_ZERO && e.fall == per) begin
			lvl = 1'b1;
		end else begin
			if (e.rise == CNT_ZERO && e.fall == CNT_ZERO) begin
				f = CNT_ONE;
			end
			if (e.rise < f) begin
				lvl = (cnt >= e.rise) && (cnt < f);
			end else begin
				lvl = 1'b0;
			end
		end
		return lvl;
	endfunction

	// Register state
	timing_s            tim_stg_reg  [NUM_CNT];
	timing_s            tim_stg_next [NUM_CNT];
	timing_s            tim_act_reg  [NUM_CNT];
	timing_s            tim_act_next [NUM_CNT];
	edge_s              edge_stg_reg [NUM_CH];
	edge_s              edge_stg_next[NUM_CH];
	edge_s              edge_act_reg [NUM_CH];
	edge_s              edge_act_next[NUM_CH];
	count_t             pre_reg      [NUM_CNT];
	count_t             pre_next     [NUM_CNT];
	count_t             cnt_reg      [NUM_CNT];
	count_t             cnt_next     [NUM_CNT];
	logic [NUM_CNT-1:0] upd_reg;
	logic [NUM_CNT-1:0] upd_next;
	logic [NUM_CNT-1:0] ist_reg;
	logic [NUM_CNT-1:0] ist_next;
	logic [NUM_CNT-1:0] mask_reg;
	logic [NUM_CNT-1:0] mask_next;
	logic [NUM_AUX-1:0] sel_reg;
	logic [NUM_AUX-1:0] sel_next;
	logic [NUM_CH-1:0]  out_reg;
	logic [NUM_CH-1:0]  out_next;
	logic [31:0]        prdata_reg;
	logic [31:0]        prdata_next;
	logic               pready_reg;
	logic               pready_next;
	logic               pslverr_reg;
	logic               pslverr_next;
	logic               irq_reg;
	logic               irq_next;

	// Decode helpers
	logic               setup;
	logic               commit;
	logic               wr_commit;
	logic               rd_commit;
	logic               mapped;
	logic               is_tim;
	logic               is_ch;
	logic               is_cnt;
	addr_t              rel_tim;
	addr_t              rel_ch;
	addr_t              rel_cnt;
	int                 tim_idx;
	int                 ch_idx;
	int                 cnt_idx;
	logic [NUM_CNT-1:0] tick;
	logic [NUM_CNT-1:0] pend;
	logic [NUM_CNT-1:0] apply;

	// Address decode of the current APB request
	always_comb begin
		setup     = i_psel && !i_penable;
		commit    = i_psel && i_penable && pready_reg;
		wr_commit = commit && i_pwrite && !pslverr_reg;
		rd_commit = commit && !i_pwrite;
		is_tim    = (i_paddr >= OFS_TIM_BASE) && (i_paddr <= OFS_TIM_LAST);
		is_ch     = (i_paddr >= OFS_CH_BASE) && (i_paddr <= OFS_CH_LAST);
		is_cnt    = (i_paddr >= OFS_CNT_BASE) && (i_paddr <= OFS_CNT_LAST);
		rel_tim   = i_paddr - OFS_TIM_BASE;
		rel_ch    = i_paddr - OFS_CH_BASE;
		rel_cnt   = i_paddr - OFS_CNT_BASE;
		tim_idx   = int'(rel_tim >> TIM_STRIDE_SH);
		ch_idx    = int'(rel_ch >> WORD_SH);
		cnt_idx   = int'(rel_cnt >> WORD_SH);
		mapped    = (i_paddr[1:0] == 2'b00) && (is_tim || is_ch || is_cnt ||
			i_paddr == OFS_CTRL || i_paddr == OFS_INT_STAT ||
			i_paddr == OFS_INT_MASK || i_paddr == OFS_AUX_SEL || i_paddr == OFS_OUT_STAT);
	end

	// Pre-scalers, counters, staging and register writes
	always_comb begin
		tim_stg_next  = tim_stg_reg;
		tim_act_next  = tim_act_reg;
		edge_stg_next = edge_stg_reg;
		edge_act_next = edge_act_reg;
		pre_next      = pre_reg;
		cnt_next      = cnt_reg;
		upd_next      = upd_reg;
		mask_next     = mask_reg;
		sel_next      = sel_reg;
		tick          = '0;
		pend          = '0;
		apply         = '0;
		for (int k = 0; k < NUM_CNT; k++) begin
			// Divider of zero behaves as divide by one
			tick[k] = ({1'b0, pre_reg[k]} + 17'h00001) >= {1'b0, tim_act_reg[k].div};
			pend[k] = tick[k] && (({1'b0, cnt_reg[k]} + 17'h00001) >= {1'b0, tim_act_reg[k].per});
			pre_next[k] = tick[k] ? CNT_ZERO : count_t'(pre_reg[k] + CNT_ONE);
			if (tick[k]) begin
				cnt_next[k] = pend[k] ? CNT_ZERO : count_t'(cnt_reg[k] + CNT_ONE);
			end
			// Staged timing is only taken over at the wrap
			apply[k] = pend[k] && upd_reg[k];
			if (apply[k]) begin
				tim_act_next[k] = tim_stg_reg[k];
				upd_next[k]     = 1'b0;
			end
		end
		// Channel stamps follow the wrap of the counter that drives them
		for (int c = 0; c < NUM_CH; c++) begin
			if (apply[cnt_of(c, sel_reg)]) begin
				edge_act_next[c] = edge_stg_reg[c];
			end
		end
		// Software writes; an update request set in the same cycle wins over the hardware clear
		if (wr_commit) begin
			if (i_paddr == OFS_CTRL) begin
				upd_next = upd_next | i_pwdata[NUM_CNT-1:0];
			end
			if (i_paddr == OFS_INT_MASK) begin
				mask_next = i_pwdata[NUM_CNT-1:0];
			end
			if (i_paddr == OFS_AUX_SEL) begin
				sel_next = i_pwdata[NUM_AUX-1:0];
			end
			if (is_tim) begin
				if (rel_tim[PER_WORD_BIT]) begin
					tim_stg_next[tim_idx].per = i_pwdata[CNT_W-1:0];
				end else begin
					tim_stg_next[tim_idx].div = i_pwdata[CNT_W-1:0];
				end
			end
			if (is_ch) begin
				edge_stg_next[ch_idx] = edge_s'(i_pwdata);
			end
		end
	end

	// Waveforms, interrupt status and its output
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			out_next[c] = level_of(cnt_reg[cnt_of(c, sel_reg)], edge_act_reg[c],
				tim_act_reg[cnt_of(c, sel_reg)].per);
		end
		// Read of the status clears only the bits it returned; new events win
		ist_next = ist_reg;
		if (rd_commit && i_paddr == OFS_INT_STAT) begin
			ist_next = ist_reg & ~prdata_reg[NUM_CNT-1:0];
		end
		ist_next = ist_next | apply;
		irq_next = |(ist_next & mask_next);
	end

	// APB answer: data captured in setup, pready high in the first access cycle
	always_comb begin
		prdata_next  = prdata_reg;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (setup) begin
			pready_next  = 1'b1;
			pslverr_next = !mapped;
			prdata_next  = DATA_ZERO;
			if (i_paddr == OFS_CTRL) begin
				prdata_next[NUM_CNT-1:0] = upd_reg;
			end
			if (i_paddr == OFS_INT_STAT) begin
				prdata_next[NUM_CNT-1:0] = ist_reg | apply;
			end
			if (i_paddr == OFS_INT_MASK) begin
				prdata_next[NUM_CNT-1:0] = mask_reg;
			end
			if (i_paddr == OFS_AUX_SEL) begin
				prdata_next[NUM_AUX-1:0] = sel_reg;
			end
			if (i_paddr == OFS_OUT_STAT) begin
				prdata_next[NUM_CH-1:0] = out_reg;
			end
			if (is_tim) begin
				prdata_next[CNT_W-1:0] = rel_tim[PER_WORD_BIT] ? tim_stg_reg[tim_idx].per
					: tim_stg_reg[tim_idx].div;
			end
			if (is_ch) begin
				prdata_next = edge_stg_reg[ch_idx];
			end
			if (is_cnt) begin
				prdata_next[CNT_W-1:0] = cnt_reg[cnt_idx];
			end
			if (!mapped) begin
				prdata_next = DATA_ZERO;
			end
		end
	end

	// State registers
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			for (int k = 0; k < NUM_CNT; k++) begin
				tim_stg_reg[k] <= '{div: RST_DIV, per: RST_PER};
				tim_act_reg[k] <= '{div: RST_DIV, per: RST_PER};
				pre_reg[k]     <= CNT_ZERO;
				cnt_reg[k]     <= CNT_ZERO;
			end
			for (int c = 0; c < NUM_CH; c++) begin
				edge_stg_reg[c] <= '{fall: RST_FALL, rise: RST_RISE};
				edge_act_reg[c] <= '{fall: RST_FALL, rise: RST_RISE};
			end
			upd_reg     <= '0;
			ist_reg     <= '0;
			mask_reg    <= '0;
			sel_reg     <= '0;
			out_reg     <= '0;
			prdata_reg  <= DATA_ZERO;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			tim_stg_reg  <= tim_stg_next;
			tim_act_reg  <= tim_act_next;
			pre_reg      <= pre_next;
			cnt_reg      <= cnt_next;
			edge_stg_reg <= edge_stg_next;
			edge_act_reg <= edge_act_next;
			upd_reg      <= upd_next;
			ist_reg      <= ist_next;
			mask_reg     <= mask_next;
			sel_reg      <= sel_next;
			out_reg      <= out_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			irq_reg      <= irq_next;
		end
	end

	// Pins: LED sink enables and GPIO waveforms
	assign o_led_current_enable = out_reg[NUM_LED-1:0];
	assign o_gpio_pwm           = out_reg[NUM_CH-1:NUM_LED];
	assign o_prdata             = prdata_reg;
	assign o_pready             = pready_reg;
	assign o_pslverr            = pslverr_reg;
	assign o_irq                = irq_reg;

endmodule

// ===== testbench/pwm_unit_chk.sv
// Purpose: Port-level assertions for the PWM unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by bind below the module
`timescale 1ns/1ns
module pwm_unit_chk
	import pwm_unit_pkg::*;
(
	input wire logic               i_clk,
	input wire logic               i_resetn,
	input wire logic               i_psel,
	input wire logic               i_penable,
	input wire logic               i_pwrite,
	input wire logic [ADDR_W-1:0]  i_paddr,
	input wire logic [31:0]        o_prdata,
	input wire logic               o_pready,
	input wire logic               o_pslverr,
	input wire logic               o_irq,
	input wire logic [NUM_LED-1:0] o_led_current_enable,
	input wire logic [NUM_AUX-1:0] o_gpio_pwm
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Bus answer timing and errors
	pready_single_a: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
	pready_setup_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no answer after setup");
	pready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable)) else $error("stray pready");
	err_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == DATA_ZERO) else $error("bad error answer");
	err_align_a: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'h0 |=> o_pslverr)
		else $error("unaligned access accepted");
	// Output status read mirrors the pins
	out_stat_a: assert property (i_psel && !i_penable && !i_pwrite && i_paddr == OFS_OUT_STAT
		|=> o_prdata[6:0] == $past({o_gpio_pwm, o_led_current_enable})) else $error("status differs");
	reset_dark_a: assert property ($rose(i_resetn) |-> !o_irq && o_led_current_enable == '0 && o_gpio_pwm == '0)
		else $error("outputs lit after reset");
	irq_clear_a: assert property ($fell(o_irq) |-> $past(i_psel && i_penable && o_pready))
		else $error("irq dropped without access");
	cover property (o_irq);
	cover property ($rose(o_led_current_enable[0]));
	cover property (o_pslverr);
endmodule
bind led_and_aux_pwm_unit pwm_unit_chk pwm_unit_chk_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_irq(o_irq), .o_led_current_enable(o_led_current_enable), .o_gpio_pwm(o_gpio_pwm));

// ===== testbench/pwm_load_model.sv
// Purpose: LED driver enables and GPIO pins seen as loads
// Assumes: Sink current flows while an enable is high
// Notes:   Counts high clocks per channel since the last clear
`timescale 1ns/1ns
module pwm_load_model (
	input  wire logic       i_clk,
	input  wire logic       i_clear,
	input  wire logic [6:0] i_drive,
	output int              o_high [7]
);
	// Accumulate on-time of each LED sink and GPIO pin
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 7; k++) begin
			o_high[k] <= i_clear ? 0 : o_high[k] + int'(i_drive[k]);
		end
	end
endmodule

// ===== testbench/tb_top.sv
// Purpose: Register-driven test of the LED and auxiliary PWM unit
// Assumes: Bus answers in one access cycle, outputs measured over whole periods
// Notes:   The first update waits out the full reset period
`timescale 1ns/1ns
module tb_top
	import pwm_unit_pkg::*;
;
	logic i_clk = 0, i_resetn = 0, psel = 0, penable = 0, pwrite = 0, clear = 0, err;
	addr_t paddr = '0;
	logic [31:0] pwdata = '0, rdata, o_prdata;
	logic o_pready, o_pslverr, o_irq;
	logic [2:0] led;
	logic [3:0] gpio;
	int hi [7];
	int miscompares = 0, checked = 0;
	led_and_aux_pwm_unit led_and_aux_pwm_unit_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq), .o_led_current_enable(led), .o_gpio_pwm(gpio));
	pwm_load_model pwm_load_model_inst (.i_clk(i_clk), .i_clear(clear), .i_drive({gpio, led}), .o_high(hi));
	initial begin
		forever #4 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One setup cycle, then access until pready
	task automatic apb(input logic wr, input addr_t a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		rdata = o_prdata;
		err = o_pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd_chk(input addr_t a, input logic [31:0] exp);
		apb(0, a, DATA_ZERO);
		chk(rdata, exp);
	endtask
	// Counts high clocks over 240 clocks, a whole number of every period used
	task automatic measure(input int e [7]);
		@(posedge i_clk);
		clear <= 1;
		@(posedge i_clk);
		clear <= 0;
		repeat (240) @(posedge i_clk);
		#1;
		for (int k = 0; k < 7; k++) chk(32'(hi[k]), 32'(e[k]));
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge i_clk);
		miscompares++;
		final_report;
	end
	initial begin
		int n;
		repeat (10) @(posedge i_clk);
		i_resetn <= 1;
		rd_chk(OFS_TIM_BASE + 8'h04, 32'h0000FFFF);
		rd_chk(OFS_CH_BASE, 32'h0000FFFF);
		apb(0, 8'h30, DATA_ZERO);
		chk({31'h0, err}, 32'h1);
		apb(1, 8'h02, DATA_ZERO);
		chk({31'h0, err}, 32'h1);
		// Stage: counter0 div2 per8, counter1 div1 per10, counter2 div3 per5
		apb(1, 8'h10, 32'h2); apb(1, 8'h14, 32'h8); apb(1, 8'h18, 32'h1);
		apb(1, 8'h1C, 32'hA); apb(1, 8'h20, 32'h3); apb(1, 8'h24, 32'h5);
		apb(1, 8'h40, 32'h0006_0002); apb(1, 8'h44, 32'h0008_0000); apb(1, 8'h48, 32'h0000_0000);
		apb(1, 8'h4C, 32'h0007_0003); apb(1, 8'h50, 32'h0004_0001);
		apb(1, 8'h54, 32'h0007_0007); apb(1, 8'h58, 32'h0002_0004);
		apb(1, OFS_AUX_SEL, 32'hA);
		rd_chk(OFS_OUT_STAT, DATA_ZERO);
		apb(1, OFS_INT_MASK, 32'h7);
		apb(1, OFS_CTRL, 32'h7);
		rd_chk(OFS_CTRL, 32'h7);
		n = 0;
		while (o_irq !== 1'b1 && n < 70000) begin
			@(posedge i_clk);
			n++;
		end
		chk({31'h0, o_irq}, 32'h1);
		rd_chk(OFS_INT_STAT, 32'h7);
		// The read-clear lands at the access edge, so look one clock later
		@(posedge i_clk);
		chk({31'h0, o_irq}, 32'h0);
		rd_chk(OFS_CTRL, DATA_ZERO);
		measure('{120, 240, 30, 96, 144, 0, 0});
		// Staged edit without request stays inactive, then masked update
		apb(1, OFS_INT_MASK, 32'h6);
		apb(1, 8'h40, 32'h0007_0002);
		measure('{120, 240, 30, 96, 144, 0, 0});
		apb(1, OFS_CTRL, 32'h1);
		repeat (40) @(posedge i_clk);
		chk({31'h0, o_irq}, 32'h0);
		rd_chk(OFS_CTRL, DATA_ZERO);
		apb(1, OFS_INT_MASK, 32'h7);
		repeat (2) @(posedge i_clk);
		chk({31'h0, o_irq}, 32'h1);
		rd_chk(OFS_INT_STAT, 32'h1);
		@(posedge i_clk);
		chk({31'h0, o_irq}, 32'h0);
		measure('{150, 240, 30, 96, 144, 0, 0});
		final_report;
	end
endmodule
